//--- hw/tsirq_map.svh
/*
  register offsets, field positions, reset values and counts of the
  timestamp interrupt block; definitions only, included by bare name.
  assumes an apb slave with 32-bit words, byte address = index * 4.
*/
`ifndef TSIRQ_MAP_SVH
`define TSIRQ_MAP_SVH

// register indices (printed offsets), byte address is index * 4
`define TSIRQ_STATUS_IDX 12'h68C
`define TSIRQ_ENABLE_IDX 12'h68E
`define TSIRQ_TOP_IDX 12'h690
`define TSIRQ_MISS_IDX 12'h692
`define TSIRQ_MISS_MASK_IDX 12'h694

// flag positions in status and enable
`define TSIRQ_P2_DLY_BIT 15
`define TSIRQ_P2_SYNC_BIT 14
`define TSIRQ_P1_DLY_BIT 13
`define TSIRQ_P1_SYNC_BIT 12
`define TSIRQ_UNIT_LSB 0

// positions in the top summary word
`define TSIRQ_TOP_STATUS_BIT 12
`define TSIRQ_TOP_ENABLE_BIT 28

// reset values
`define TSIRQ_STATUS_RST 16'h0000
`define TSIRQ_ENABLE_RST 16'h0000
`define TSIRQ_MISS_RST 16'h0000

// counts
`define TSIRQ_NUM_UNITS 12
`define TSIRQ_FLAGS 16

`endif

//--- hw/tsirq_pkg.sv
/*
  types of the timestamp interrupt block.
  assumes the map header supplies the numbers.
*/
package tsirq_pkg;

  // one bit per timestamp event, laid out as the status word
  typedef struct packed {
    logic p2_dly;
    logic p2_sync;
    logic p1_dly;
    logic p1_sync;
    logic [11:0] unit;
  } tsirq_evt_t;

  // bus answer phase
  typedef enum logic [1:0] {
    TSIRQ_IDLE = 2'b00,
    TSIRQ_ACCESS = 2'b01
  } tsirq_state_t;

endpackage

//--- hw/tsirq_top.sv
/*
  timestamp interrupt status and enable registers with apb slave,
  lost-event log and one level interrupt output.
  assumes event pulses come from logic on pclk, one cycle each, and
  an apb master that holds its request until pready.
*/
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "tsirq_map.svh"

module tsirq_top
  import tsirq_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int NUM_UNITS = `TSIRQ_NUM_UNITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tsirq_evt_t evt_i,
  output logic top_irq_status,
  output logic top_irq_enable,
  output logic irq
);

  // refuse shapes the fixed bit layout cannot serve
  initial begin
    if (ADDR_W < 14) begin
      $error("tsirq_top: ADDR_W must be at least 14");
    end
    if (NUM_UNITS != `TSIRQ_NUM_UNITS) begin
      $error("tsirq_top: NUM_UNITS must be 12");
    end
  end

  // address match against a register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    reg_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // write mask of the low halfword from the byte strobes
  function automatic logic [15:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[1]}}, {8{s[0]}}};
  endfunction

  tsirq_state_t state_r;
  tsirq_state_t state_nxt;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] enable_r;
  logic [15:0] enable_nxt;
  logic [15:0] miss_r;
  logic [15:0] miss_nxt;
  logic [15:0] miss_mask_r;
  logic [15:0] miss_mask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic top_status_r;
  logic top_enable_r;
  logic rd_miss_r;
  logic [15:0] evt_v;
  logic setup;
  logic acc;
  logic hit_status;
  logic hit_enable;
  logic hit_top;
  logic hit_miss;
  logic hit_mask;
  logic mapped;
  logic [15:0] wmask;
  logic [15:0] w1c;
  logic [15:0] rclr;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign top_irq_status = top_status_r;
  assign top_irq_enable = top_enable_r;

  // flatten events to the status layout
  // units onto low bits
  assign evt_v = evt_i;

  // bus phase decode
  assign setup = (state_r == TSIRQ_IDLE) && psel && !penable;
  assign acc = (state_r == TSIRQ_ACCESS) && psel && penable && pready_r;
  assign hit_status = reg_hit(paddr, `TSIRQ_STATUS_IDX);
  assign hit_enable = reg_hit(paddr, `TSIRQ_ENABLE_IDX);
  assign hit_top = reg_hit(paddr, `TSIRQ_TOP_IDX);
  assign hit_miss = reg_hit(paddr, `TSIRQ_MISS_IDX);
  assign hit_mask = reg_hit(paddr, `TSIRQ_MISS_MASK_IDX);
  assign mapped = hit_status || hit_enable || hit_top || hit_miss || hit_mask;
  assign wmask = lane_mask(pstrb) & pwdata[15:0];

  // answer state: ready during the first access cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TSIRQ_IDLE: begin
        if (setup) begin
          state_nxt = TSIRQ_ACCESS;
        end
      end
      TSIRQ_ACCESS: begin
        if (acc || !psel) begin
          state_nxt = TSIRQ_IDLE;
        end
      end
      default: begin
        state_nxt = TSIRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TSIRQ_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ready and error flops, loaded at the edge that ends the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
    end
  end

  // read data captured at setup
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (hit_status) begin
        prdata_nxt[15:0] = status_r;
      end else if (hit_enable) begin
        prdata_nxt[15:0] = enable_r;
      end else if (hit_top) begin
        prdata_nxt[`TSIRQ_TOP_STATUS_BIT] = top_status_r;
        prdata_nxt[`TSIRQ_TOP_ENABLE_BIT] = top_enable_r;
      end else if (hit_miss) begin
        prdata_nxt[15:0] = miss_r;
      end else if (hit_mask) begin
        prdata_nxt[15:0] = miss_mask_r;
      end else begin
        prdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      rd_miss_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      rd_miss_r <= setup && !pwrite && hit_miss;
    end
  end

  // clear masks, effective only at the access edge
  // write one clears
  assign w1c = (acc && pwrite && hit_status) ? wmask : 16'h0000;
  // read clears only what was returned
  assign rclr = (acc && rd_miss_r) ? prdata_r[15:0] : 16'h0000;

  // sticky status flags
  always_comb begin
    status_nxt = (status_r & ~w1c) | evt_v;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `TSIRQ_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // enable register, byte-lane write
  always_comb begin
    enable_nxt = enable_r;
    if (acc && pwrite && hit_enable) begin
      enable_nxt = (enable_r & ~lane_mask(pstrb)) | wmask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= `TSIRQ_ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // lost-event log: event on a flag already set; read clears
  always_comb begin
    miss_nxt = (miss_r & ~rclr) | (evt_v & status_r);
    miss_mask_nxt = miss_mask_r;
    if (acc && pwrite && hit_mask) begin
      miss_mask_nxt = (miss_mask_r & ~lane_mask(pstrb)) | wmask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_r <= `TSIRQ_MISS_RST;
      miss_mask_r <= `TSIRQ_MISS_RST;
    end else begin
      miss_r <= miss_nxt;
      miss_mask_r <= miss_mask_nxt;
    end
  end

  // summary bits and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_status_r <= 1'b0;
      top_enable_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      top_status_r <= |status_nxt;
      top_enable_r <= |enable_nxt;
      irq_r <= (|(status_nxt & enable_nxt)) || (|(miss_nxt & miss_mask_nxt));
    end
  end

  // checks
  property p_p2_dly;
    @(posedge pclk) disable iff (!presetn)
    evt_i.p2_dly |=> status_r[`TSIRQ_P2_DLY_BIT];
  endproperty
  a_p2_dly: assert property (p_p2_dly) else $error("port 2 delay flag not set");

  property p_p2_sync;
    @(posedge pclk) disable iff (!presetn)
    evt_i.p2_sync |=> status_r[`TSIRQ_P2_SYNC_BIT] && top_irq_status;
  endproperty
  a_p2_sync: assert property (p_p2_sync) else $error("port 2 sync flag not set");

  property p_p1_dly;
    @(posedge pclk) disable iff (!presetn)
    evt_i.p1_dly |=> status_r[`TSIRQ_P1_DLY_BIT];
  endproperty
  a_p1_dly: assert property (p_p1_dly) else $error("port 1 delay flag not set");

  property p_p1_sync;
    @(posedge pclk) disable iff (!presetn)
    evt_i.p1_sync |=> status_r[`TSIRQ_P1_SYNC_BIT];
  endproperty
  a_p1_sync: assert property (p_p1_sync) else $error("port 1 sync flag not set");

  property p_unit12;
    @(posedge pclk) disable iff (!presetn)
    evt_i.unit[11] |=> status_r[11];
  endproperty
  a_unit12: assert property (p_unit12) else $error("unit 12 flag not set");

  property p_unit1;
    @(posedge pclk) disable iff (!presetn)
    (evt_v == 16'h0001) && !status_r[0] |=> status_r[0] && (status_r[15:1] == $past(status_r[15:1]));
  endproperty
  a_unit1: assert property (p_unit1) else $error("unit 1 not on bit 0");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    !(acc && pwrite && hit_status) |=> ((status_r & $past(status_r)) == $past(status_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a write");

  property p_top_status;
    @(posedge pclk) disable iff (!presetn)
    top_irq_status == (|status_r);
  endproperty
  a_top_status: assert property (p_top_status) else $error("top status not OR of flags");

  property p_enable_rst;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (enable_r == 16'h0000) && !irq;
  endproperty
  a_enable_rst: assert property (p_enable_rst) else $error("enable not zero after reset");

  property p_top_enable;
    @(posedge pclk) disable iff (!presetn)
    top_irq_enable == (|enable_r);
  endproperty
  a_top_enable: assert property (p_top_enable) else $error("top enable not OR of enables");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    irq == ((|(status_r & enable_r)) || (|(miss_r & miss_mask_r)));
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt not gated by enables");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (evt_i.p1_sync && w1c[`TSIRQ_P1_SYNC_BIT]) |=> status_r[`TSIRQ_P1_SYNC_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");

  property p_w1c_clears;
    @(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_status && (w1c[3] && !evt_v[3])) |=> !status_r[3];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("write one did not clear");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_status && !w1c[3] && status_r[3]) |=> status_r[3];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("write zero cleared a flag");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_enable && (pstrb[1:0] == 2'b11)) |=> (enable_r == $past(pwdata[15:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write did not land");

  c_w1c: cover property (@(posedge pclk) disable iff (!presetn) acc && pwrite && hit_status && (w1c != 16'h0000));
  c_collide: cover property (@(posedge pclk) disable iff (!presetn) (evt_v & w1c) != 16'h0000);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_b2b: cover property (@(posedge pclk) disable iff (!presetn) acc ##1 acc ##1 1'b1);
  c_miss: cover property (@(posedge pclk) disable iff (!presetn) (miss_r & miss_mask_r) != 16'h0000);

endmodule

//--- tb/tsirq_host.sv
/*
  apb host model standing in for the software on the far side.
  assumes a slave that answers within 16 access cycles.
*/
`timescale 1ns/10ps
module tsirq_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // one transfer: setup, then access held until pready
  // byte strobes fixed at 4'h3, low halfword only
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- tb/test_ptp_timestamp_irq_status.sv
/*
  self-checking bench of the timestamp interrupt block.
  assumes the host model in tsirq_host.sv and the map header.
*/
`timescale 1ns/10ps
`include "tsirq_map.svh"
module test_ptp_timestamp_irq_status import tsirq_pkg::*; ;
  localparam logic [15:0] ST_A = 16'(`TSIRQ_STATUS_IDX * 4);
  localparam logic [15:0] EN_A = 16'(`TSIRQ_ENABLE_IDX * 4);
  localparam logic [15:0] TP_A = 16'(`TSIRQ_TOP_IDX * 4);
  localparam logic [15:0] MS_A = 16'(`TSIRQ_MISS_IDX * 4);
  localparam logic [15:0] MK_A = 16'(`TSIRQ_MISS_MASK_IDX * 4);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic top_irq_status, top_irq_enable, irq, e, ok;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb;
  tsirq_evt_t evt;
  int errors, samples_checked;

  tsirq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_i(evt), .top_irq_status(top_irq_status),
    .top_irq_enable(top_irq_enable), .irq(irq));
  tsirq_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // value compare
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, got);
      errors++;
    end
  endtask

  // bus access, a hang ends the run
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    host.xfer(wr, a, wd, d, e, ok);
    if (!ok) begin
      errors++;
      end_sim();
    end
  endtask

  // one-cycle event pulse, outputs settled after
  task automatic pulse(input logic [15:0] v);
    @(posedge pclk);
    evt <= tsirq_evt_t'(v);
    @(posedge pclk);
    evt <= '0;
    #1;
  endtask

  // reset values
  task automatic t_reset();
    apb(1'b0, ST_A, 32'h0);
    chk("status", 32'h0, d);
    apb(1'b0, EN_A, 32'h0);
    chk("enable", 32'h0, d);
    chk("outputs", 32'h0, {top_irq_status, top_irq_enable, irq});
    $display("test reset done");
  endtask

  // each event sets its own flag, which stays until written one
  task automatic t_flags();
    for (int i = 0; i < 16; i++) begin
      pulse(16'h1 << i);
      chk("top_irq_status", 32'h1, top_irq_status);
      chk("irq", 32'h0, irq);
      apb(1'b1, ST_A, 32'hFFFF_0000);
      apb(1'b0, ST_A, 32'h0);
      chk("status", 32'h1 << i, d);
      apb(1'b1, ST_A, 32'h1 << i);
      apb(1'b0, ST_A, 32'h0);
      chk("cleared", 32'h0, d);
      chk("top_irq_status", 32'h0, top_irq_status);
    end
    $display("test flags done");
  endtask

  // enables gate the interrupt per flag
  task automatic t_enable();
    apb(1'b1, EN_A, 32'h0000_FFFF);
    apb(1'b0, EN_A, 32'h0);
    chk("enable", 32'hFFFF, d);
    chk("top_irq_enable", 32'h1, top_irq_enable);
    apb(1'b1, EN_A, 32'h0000_0008);
    pulse(16'h0020);
    chk("irq", 32'h0, irq);
    pulse(16'h0008);
    chk("irq", 32'h1, irq);
    apb(1'b1, ST_A, 32'h0000_FFFF);
    #1;
    chk("irq", 32'h0, irq);
    apb(1'b1, EN_A, 32'h0);
    #1;
    chk("top_irq_enable", 32'h0, top_irq_enable);
    $display("test enable done");
  endtask

  // event in the clearing cycle wins, unmapped access refused
  task automatic t_race();
    fork
      apb(1'b1, ST_A, 32'h0000_1000);
      begin
        repeat (2) @(posedge pclk);
        evt <= tsirq_evt_t'(16'h1000);
        @(posedge pclk);
        evt <= '0;
      end
    join
    apb(1'b0, ST_A, 32'h0);
    chk("status", 32'h1000, d);
    apb(1'b0, ST_A + 16'h4, 32'h0);
    chk("pslverr", 32'h1, e);
    $display("test race done");
  endtask

  // lost-event log, summary word, then a reset in mid-run
  task automatic t_miss();
    apb(1'b1, MK_A, 32'h0000_1000);
    pulse(16'h1000);
    chk("irq", 32'h1, irq);
    apb(1'b1, MS_A, 32'h0);
    apb(1'b0, MS_A, 32'h0);
    chk("miss", 32'h1000, d);
    apb(1'b0, MS_A, 32'h0);
    chk("miss", 32'h0, d);
    chk("irq", 32'h0, irq);
    apb(1'b1, TP_A, 32'h0);
    chk("pslverr", 32'h0, e);
    apb(1'b0, TP_A, 32'h0);
    chk("top", 32'h0000_1000, d);
    apb(1'b1, EN_A, 32'h0000_FFFF);
    apb(1'b0, TP_A, 32'h0);
    chk("top", 32'h1000_1000, d);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EN_A, 32'h0);
    chk("enable", 32'h0, d);
    chk("outputs", 32'h0, {top_irq_status, top_irq_enable, irq});
    $display("test miss done");
  endtask

  // main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    evt = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_enable();
    t_race();
    t_miss();
    end_sim();
  end
endmodule
